// File: rtl/dram_ctl_pkg.sv
// constants and carrier types for the page mode dram controller
package dram_ctl_pkg;
   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_PS          = 5000;
   localparam int T_PAUSE_US      = 200;
   localparam int C_PAUSE         = (T_PAUSE_US * 1000000) / CLK_PS;
   localparam int T_REF_DIST_US   = 16400;
   localparam int T_REF_BURST_US  = 8200;
   localparam int N_ROWS          = 1024;
   // per-row interval for distributed refresh, rounded down
   // 64-bit product: the microsecond to picosecond scale overflows int
   localparam int C_REF_INTERVAL  =
      int'((longint'(T_REF_DIST_US) * 1000000) / (CLK_PS * N_ROWS));
   localparam int C_REF_BURST     = int'((longint'(T_REF_BURST_US) * 1000000) / CLK_PS);
   localparam int N_INIT          = 8;
   localparam int T_RP_NS         = 50;
   localparam int T_RAS_NS        = 80;
   localparam int T_RCD_NS        = 20;
   localparam int T_CAS_NS        = 20;
   localparam int T_CP_NS         = 10;
   localparam int T_CAC_NS        = 40;
   localparam int T_RAH_NS        = 10;
   localparam int T_CSR_NS        = 10;
   localparam int T_CHR_NS        = 12;
   localparam int C_RP   = (T_RP_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int C_RAS  = (T_RAS_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int C_RCD  = (T_RCD_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int C_CAS  = (T_CAS_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int C_CP   = (T_CP_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int C_CAC  = (T_CAC_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int C_RAH  = (T_RAH_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int C_CSR  = (T_CSR_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int C_CHR  = (T_CHR_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int CW     = 24;
   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int AW     = 10;
   localparam int DW     = 36;
   localparam int LANES  = 4;
   localparam int LANE_W = 9;
   localparam int HALVES = 2;
   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic          write;
      logic          half;
      logic [AW-1:0] row;
      logic [AW-1:0] col;
      logic [DW-1:0] wdata;
      logic [LANES-1:0] lanes;
   } req_t;

   typedef struct packed {
      logic [HALVES-1:0] row_strobe_n;
      logic [LANES-1:0]  col_strobe_n;
      logic              write_en_n;
      logic [AW-1:0]     addr;
   } pins_t;
endpackage

// File: rtl/dram_wait.sv
`timescale 1ns/1ps
// wait counter: loads a count and reports when it has run out
module dram_wait (
   input  wire logic                          clk,
   input  wire logic                          arst_n,
   input  wire logic                          load,
   input  wire logic [dram_ctl_pkg::CW-1:0]   count,
   output logic                               done
);
   logic [dram_ctl_pkg::CW-1:0] remain;
   logic [dram_ctl_pkg::CW-1:0] next_remain;

   always_comb begin
      if (load) begin
         next_remain = count;
      end else if (remain != '0) begin
         next_remain = remain - 24'h000001;
      end else begin
         next_remain = remain;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         remain <= '0;
      end else begin
         remain <= next_remain;
      end
   end

   // no path from load to done, so callers may load on done
   assign done = (remain == '0);
endmodule

// File: rtl/dram_ctl.sv
`timescale 1ns/1ps
// host controller driving a fast page mode dram module
// How it works
// (RQ1) 200us strobes idle, then eight row-only cycles
// (RQ2) cbr mode: eight cas-before-ras init cycles instead
// (RQ3) distributed: 1024 rows per 16.4 ms
// (RQ4) burst: 1024 rows within 8.2 ms; the code bursts 512 owed rows about every 8.2 ms
// (RQ5) early write keeps module outputs off
// (RQ6) write enable held high after read ends
// (RQ7) row-only refresh keeps column strobes high
// (RQ8) page mode: row held, column strobe toggles
// (RQ9) two million 36-bit words, muxed address
// (RQ10) row latched on ras fall, column on cas
// (RQ11) cas per nine-bit lane, ras per half
module dram_ctl (
   input  wire logic                           clk,
   input  wire logic                           arst_n,
   input  wire logic                           use_cbr,
   input  wire logic                           burst_mode,
   input  wire logic                           req_valid,
   input  wire dram_ctl_pkg::req_t             req,
   output logic                                req_ready,
   output logic                                rd_valid,
   output logic [dram_ctl_pkg::DW-1:0]         rd_data,
   output logic                                init_done,
   output dram_ctl_pkg::pins_t                 pins,
   output logic [dram_ctl_pkg::DW-1:0]         dq_out,
   output logic                                dq_oe,
   input  wire logic [dram_ctl_pkg::DW-1:0]    dq_in
);
   // ----------------------------------------------------------------
   // states
   // ----------------------------------------------------------------
   typedef enum logic [9:0] {
      S_PAUSE = 10'h001, S_IDLE = 10'h002, S_ROW = 10'h004, S_COL = 10'h008,
      S_CPRE  = 10'h010, S_CLOSE = 10'h020, S_PRE = 10'h040, S_RFROW = 10'h080,
      S_CBR   = 10'h100, S_CBRRAS = 10'h200
   } state_t;

   // reload one short so the timer period is the whole interval
   localparam int RC = dram_ctl_pkg::C_REF_INTERVAL - 1;

   state_t                         state, next_state;
   dram_ctl_pkg::pins_t            next_pins;
   logic [dram_ctl_pkg::DW-1:0]    next_dq_out, next_rd_data;
   logic                           next_dq_oe, next_rd_valid, next_req_ready, next_init_done;
   logic [3:0]                     init_cnt, next_init_cnt;
   logic [dram_ctl_pkg::AW-1:0]    ref_row, next_ref_row;
   logic [dram_ctl_pkg::CW-1:0]    ref_timer, next_ref_timer;
   logic [10:0]                    ref_owed, next_ref_owed;
   dram_ctl_pkg::req_t             cur, next_cur;
   logic                           wt_load;
   logic [dram_ctl_pkg::CW-1:0]    wt_count;
   logic                           wt_done;
   logic                           pause_armed;
   logic                           draining, next_draining;

   dram_wait u_wait (
      .clk    (clk),
      .arst_n (arst_n),
      .load   (wt_load),
      .count  (wt_count),
      .done   (wt_done)
   );

   function automatic logic [dram_ctl_pkg::HALVES-1:0] half_sel(input logic h);
      half_sel = h ? 2'b01 : 2'b10;
   endfunction

   // ----------------------------------------------------------------
   // refresh budget
   // ----------------------------------------------------------------
   logic refresh_due;
   logic ref_taken;
   always_comb begin
      next_ref_timer = ref_timer;
      next_ref_owed  = ref_owed;
      next_draining  = burst_mode && refresh_due;                  // [RQ4]
      if (ref_timer == '0) begin
         next_ref_timer = RC[dram_ctl_pkg::CW-1:0];
         if (init_done) begin
            // burst mode lets debt build to half the array, 512 rows [RQ4]
            next_ref_owed = ref_owed + 11'h001;                 // [RQ3]
         end
      end else begin
         next_ref_timer = ref_timer - 24'h000001;
      end
      if (ref_taken && next_ref_owed != '0) begin
         next_ref_owed = next_ref_owed - 11'h001;
      end
   end
   // distributed refreshes each row as owed; burst waits for 512 owed rows
   // once a burst starts it drains the whole debt back to back
   assign refresh_due = burst_mode ? (ref_owed >= 11'h200 || (draining && ref_owed != '0))
                                   : (ref_owed != '0);                          // [RQ4]

   // ----------------------------------------------------------------
   // main sequencer
   // ----------------------------------------------------------------
   always_comb begin
      next_state     = state;
      next_pins      = pins;
      next_dq_out    = dq_out;
      next_dq_oe     = dq_oe;
      next_rd_data   = rd_data;
      next_rd_valid  = 1'b0;
      next_req_ready = 1'b0;
      next_init_done = init_done;
      next_init_cnt  = init_cnt;
      next_ref_row   = ref_row;
      next_cur       = cur;
      wt_load        = 1'b0;
      wt_count       = '0;
      ref_taken      = 1'b0;
      case (state)
         S_PAUSE: begin
            // strobes stay high for the power-up pause [RQ1]
            if (!pause_armed) begin
               wt_load  = 1'b1;
               wt_count = dram_ctl_pkg::C_PAUSE[dram_ctl_pkg::CW-1:0];         // [RQ1]
            end else if (wt_done) begin
               next_state = use_cbr ? S_CBR : S_RFROW;                   // [RQ2]
            end
         end
         S_IDLE: begin
            // an offered request is always taken, refresh follows it
            if (req_valid && req_ready) begin
               next_cur          = req;
               next_pins.addr    = req.row;
               next_pins.row_strobe_n = ~half_sel(req.half);            // [RQ11] [RQ10]
               next_pins.write_en_n   = ~req.write;                      // [RQ5]
               if (req.write) begin
                  next_dq_out = req.wdata;
                  next_dq_oe  = 1'b1;
               end
               wt_load  = 1'b1;
               wt_count = dram_ctl_pkg::C_RAH[dram_ctl_pkg::CW-1:0];
               next_state = S_ROW;
            end else if (refresh_due || !init_done) begin
               next_state = use_cbr ? S_CBR : S_RFROW;
            end else begin
               next_req_ready = 1'b1;
            end
         end
         S_ROW: begin
            next_pins.addr = cur.col;
            if (wt_done) begin
               // lane strobes, write enable already low for early write [RQ5]
               next_pins.col_strobe_n = ~cur.lanes;                      // [RQ11] [RQ9]
               wt_load  = 1'b1;
               wt_count = dram_ctl_pkg::C_CAC[dram_ctl_pkg::CW-1:0];
               next_state = S_COL;
            end
         end
         S_COL: begin
            if (wt_done) begin
               if (!cur.write) begin
                  next_rd_data  = dq_in;
                  next_rd_valid = 1'b1;
               end
               next_pins.col_strobe_n = '1;
               wt_load  = 1'b1;
               wt_count = dram_ctl_pkg::C_CP[dram_ctl_pkg::CW-1:0];
               next_state = S_CPRE;
            end
         end
         S_CPRE: begin
            // same row and kind: stay in page, toggle column strobe [RQ8]
            if (wt_done) begin
               if (req_valid && req_ready) begin
                  next_cur = req;
                  next_pins.addr = req.col;
                  next_pins.col_strobe_n = ~req.lanes;                  // [RQ8]
                  if (req.write) begin
                     next_dq_out = req.wdata;
                  end
                  wt_load  = 1'b1;
                  wt_count = dram_ctl_pkg::C_CAC[dram_ctl_pkg::CW-1:0];
                  next_state = S_COL;
               end else if (!req_ready && req_valid && !refresh_due && req.row == cur.row
                            && req.half == cur.half && req.write == cur.write) begin
                  // offer only for a page hit, so an offer is never refused
                  next_req_ready = 1'b1;
               end else begin
                  next_state = S_CLOSE;
               end
            end
         end
         S_CLOSE: begin
            next_pins.row_strobe_n = '1;
            next_dq_oe = 1'b0;
            wt_load  = 1'b1;
            wt_count = dram_ctl_pkg::C_RP[dram_ctl_pkg::CW-1:0];
            next_state = S_PRE;
         end
         S_PRE: begin
            // write enable returns high only after ras is high [RQ6]
            next_pins.write_en_n = 1'b1;                                 // [RQ6]
            if (wt_done) begin
               next_state = S_IDLE;
            end
         end
         S_RFROW: begin
            // column strobes stay high, row address only [RQ7]
            next_pins.col_strobe_n = '1;                                 // [RQ7]
            next_pins.addr         = ref_row;
            next_pins.row_strobe_n = '0;
            next_ref_row = ref_row + 10'h001;
            wt_load  = 1'b1;
            wt_count = dram_ctl_pkg::C_RAS[dram_ctl_pkg::CW-1:0];
            next_state = S_CBRRAS;
         end
         S_CBR: begin
            next_pins.col_strobe_n = '0;                                 // [RQ2]
            wt_load  = 1'b1;
            wt_count = dram_ctl_pkg::C_CSR[dram_ctl_pkg::CW-1:0];
            next_state = S_CBRRAS;
            next_init_cnt = init_cnt;
         end
         S_CBRRAS: begin
            if (wt_done && pins.row_strobe_n == '1) begin
               next_pins.row_strobe_n = '0;
               wt_load  = 1'b1;
               wt_count = dram_ctl_pkg::C_RAS[dram_ctl_pkg::CW-1:0];
            end else if (wt_done) begin
               next_pins.row_strobe_n = '1;
               next_pins.col_strobe_n = '1;
               if (init_done) begin
                  ref_taken = 1'b1;
               end else begin
                  next_init_cnt = init_cnt + 4'h1;
                  if (init_cnt == 4'(dram_ctl_pkg::N_INIT - 1)) begin
                     next_init_done = 1'b1;                              // [RQ1] [RQ2]
                  end
               end
               wt_load  = 1'b1;
               wt_count = dram_ctl_pkg::C_RP[dram_ctl_pkg::CW-1:0];
               next_state = S_PRE;
            end
         end
         default: begin
            next_state = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state     <= S_PAUSE;
         pins      <= '{row_strobe_n: '1, col_strobe_n: '1, write_en_n: 1'b1, addr: '0};
         dq_out    <= '0;
         dq_oe     <= 1'b0;
         rd_data   <= '0;
         rd_valid  <= 1'b0;
         req_ready <= 1'b0;
         init_done <= 1'b0;
         init_cnt  <= '0;
         ref_row   <= '0;
         ref_timer <= '0;
         ref_owed  <= '0;
         cur       <= '0;
         pause_armed <= 1'b0;
         draining  <= 1'b0;
      end else begin
         state     <= next_state;
         pins      <= next_pins;
         dq_out    <= next_dq_out;
         dq_oe     <= next_dq_oe;
         rd_data   <= next_rd_data;
         rd_valid  <= next_rd_valid;
         req_ready <= next_req_ready;
         init_done <= next_init_done;
         init_cnt  <= next_init_cnt;
         ref_row   <= next_ref_row;
         ref_timer <= next_ref_timer;
         ref_owed  <= next_ref_owed;
         cur       <= next_cur;
         // power-up pause is loaded in the first cycle out of reset
         pause_armed <= 1'b1;
         draining  <= next_draining;
      end
   end
endmodule

// File: tb/dram_model.sv
// behavioural model of the fast page mode dram module
`timescale 1ns/1ps
module dram_model (
   input  wire logic                        clk,
   input  wire dram_ctl_pkg::pins_t         pins,
   input  wire logic [dram_ctl_pkg::DW-1:0] dq_out,
   input  wire logic                        dq_oe,
   output logic      [dram_ctl_pkg::DW-1:0] dq_in
);
   // ----------------------------------------------------------------
   // array, address latches and data pins
   // ----------------------------------------------------------------
   logic [35:0]         mem [int]; // two million 36-bit words
   dram_ctl_pkg::pins_t q    = '1;
   logic [9:0]          row  = '0;
   logic                half = 1'b0;
   logic                ew   = 1'b0;
   logic                acc  = 1'b0;
   int                  key  = 0;
   initial dq_in = '0;
   always @(posedge clk) begin
      if (&q.row_strobe_n && !(&pins.row_strobe_n) && &pins.col_strobe_n) begin
         row = pins.addr;
         half = !pins.row_strobe_n[0];
      end
      if (&pins.row_strobe_n)
         acc = 1'b0;
      if (&q.col_strobe_n && !(&pins.col_strobe_n) && !(&pins.row_strobe_n)) begin
         key = {half, row, pins.addr};
         acc = 1'b1;
         ew = !pins.write_en_n;
         if (!mem.exists(key))
            mem[key] = '0;
         for (int i = 0; i < 4; i++)
            if (ew && !pins.col_strobe_n[i])
               mem[key][i*9 +: 9] = dq_oe ? dq_out[i*9 +: 9] : ~dq_out[i*9 +: 9];
      end
      for (int i = 0; i < 4; i++) // drives reads only, never refresh or early write
         dq_in[i*9 +: 9] <= (acc && !ew && !pins.col_strobe_n[i]) ? mem[key][i*9 +: 9]
                                                                  : ~dq_in[i*9 +: 9];
      q <= pins;
   end
endmodule

// File: tb/dram_ctl_sva.sv
// assertions on the ports of the page mode dram controller
`timescale 1ns/1ps
module dram_ctl_chk (
   input wire logic                clk,
   input wire logic                arst_n,
   input wire logic                use_cbr,
   input wire logic                burst_mode,
   input wire logic                req_ready,
   input wire logic                rd_valid,
   input wire logic                init_done,
   input wire dram_ctl_pkg::pins_t pins,
   input wire logic                dq_oe
);
   // ----------------------------------------------------------------
   // refresh gap counter
   // ----------------------------------------------------------------
   localparam int GAP_D = dram_ctl_pkg::C_REF_INTERVAL + 64;
   localparam int GAP_B = dram_ctl_pkg::C_REF_BURST;
   logic        ras_on;
   logic        cas_on;
   logic        ras_q;
   logic [23:0] gap;
   logic [23:0] next_gap;
   assign ras_on = !(&pins.row_strobe_n);
   assign cas_on = !(&pins.col_strobe_n);
   always_comb next_gap = (!init_done || (ras_on && !ras_q)) ? 24'h0 : gap + 24'h1;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         gap   <= 24'h0;
         ras_q <= 1'b0;
      end else begin
         gap   <= next_gap;
         ras_q <= ras_on;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   a_ready_after_init: assert property (!init_done |-> !req_ready)
      else $error("request offered before init");
   a_idle_boot: assert property ($rose(arst_n) |-> !ras_on && !cas_on)
      else $error("strobes active after reset");
   a_init_row_only: assert property (!init_done && !use_cbr && ras_on |-> !cas_on)
      else $error("column strobe during row-only init");
   a_cbr_order: assert property (!init_done && use_cbr && $rose(ras_on) |-> cas_on)
      else $error("row strobe before column strobe in cbr init");
   a_refresh_dist: assert property (init_done && !burst_mode |-> gap < GAP_D)
      else $error("distributed refresh too late");
   a_refresh_burst: assert property (init_done && burst_mode |-> gap < GAP_B)
      else $error("burst refresh budget exceeded");
   a_early_write: assert property ($rose(cas_on) && ras_on && !pins.write_en_n |-> $past(!pins.write_en_n))
      else $error("write enable not ahead of column strobe");
   a_we_read_hold: assert property ($fell(pins.write_en_n) |-> !$past(cas_on))
      else $error("write enable fell inside read");
   a_ras_pulse: assert property ($rose(ras_on) |-> ras_on[*8])
      else $error("row strobe pulse too short");
   a_cas_needs_ras: assert property ($rose(cas_on) && !use_cbr |-> ras_on)
      else $error("column strobe without row strobe");
   a_read_no_drive: assert property (cas_on && pins.write_en_n |-> !dq_oe)
      else $error("controller drives data during read");
   c_read: cover property (rd_valid);
   c_page: cover property (ras_on && $fell(cas_on) ##[1:8] ras_on && $rose(cas_on));
   c_ras_only: cover property (init_done && $rose(ras_on) && !cas_on);
endmodule
bind dram_ctl dram_ctl_chk u_dram_ctl_chk (.clk, .arst_n, .use_cbr, .burst_mode, .req_ready,
   .rd_valid, .init_done, .pins, .dq_oe);

// File: tb/tb_dram_ctl.sv
// self-checking bench for the page mode dram controller
`timescale 1ns/1ps
module tb_dram_ctl;
   // ----------------------------------------------------------------
   // signals, model and design
   // ----------------------------------------------------------------
   logic                        clk, arst_n, use_cbr, burst_mode, req_valid;
   logic                        req_ready, rd_valid, init_done, dq_oe;
   logic [dram_ctl_pkg::DW-1:0] rd_data, dq_out, dq_in;
   dram_ctl_pkg::req_t          req;
   dram_ctl_pkg::pins_t         pins;
   logic [35:0]                 em [int];
   logic [31:0]                 rs = 32'h5f;
   int                          errors = 0;
   int                          checks_done = 0;
   int                          cyc = 0;
   dram_ctl u_dram_ctl (.clk, .arst_n, .use_cbr, .burst_mode, .req_valid, .req, .req_ready,
      .rd_valid, .rd_data, .init_done, .pins, .dq_out, .dq_oe, .dq_in);
   dram_model u_dram_model (.clk, .pins, .dq_out, .dq_oe, .dq_in);
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   function automatic logic [31:0] rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction
   function automatic logic [35:0] merge(logic [35:0] o, logic [35:0] d, logic [3:0] ln);
      for (int i = 0; i < 4; i++)
         if (ln[i])
            o[i*9 +: 9] = d[i*9 +: 9];
      return o;
   endfunction
   task automatic chk_data(logic [35:0] got, logic [35:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t read data %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_flag(logic got, logic exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t flag %b expected %b", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // reset, transfers and scenarios
   // ----------------------------------------------------------------
   task automatic boot(logic cbr, logic bm);
      int n;
      n = 0;
      @(posedge clk);
      arst_n <= 1'b0;
      use_cbr <= cbr;
      burst_mode <= bm;
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      @(negedge clk);
      chk_flag(init_done, 1'b0);
      while (init_done !== 1'b1 && n < 250000) begin
         @(negedge clk);
         n++;
      end
      chk_flag(init_done, 1'b1);
   endtask
   task automatic xfer(logic w, logic h, logic [9:0] r, logic [9:0] c, logic [35:0] d,
                       logic [3:0] ln);
      int n;
      int k;
      n = 0;
      k = {h, r, c};
      @(posedge clk);
      req_valid <= 1'b1;
      req <= '{write: w, half: h, row: r, col: c, wdata: d, lanes: ln};
      do begin
         @(negedge clk);
         n++;
      end while (req_ready !== 1'b1 && n < 2000);
      chk_flag(req_ready, 1'b1);
      @(posedge clk);
      req_valid <= 1'b0;
      n = 0;
      if (w)
         em[k] = merge(em.exists(k) ? em[k] : 36'h0, d, ln);
      else begin
         do begin
            @(negedge clk);
            n++;
         end while (rd_valid !== 1'b1 && n < 100);
         chk_flag(rd_valid, 1'b1);
         chk_data(rd_data, em.exists(k) ? em[k] : 36'h0);
      end
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 100000) begin
         errors++;
         wrap_up();
      end
   end
   initial begin
      logic [31:0] v;
      arst_n = 1'b0;
      use_cbr = 1'b0;
      burst_mode = 1'b0;
      req_valid = 1'b0;
      req = '0;
      for (int m = 0; m < 3; m++) begin
         // burst mode follows the cbr run without a third power-up pause
         if (m < 2) begin
            boot(m == 1, 1'b0);
         end else begin
            @(posedge clk);
            burst_mode <= 1'b1;
         end
         for (int i = 0; i < 8; i++)
            xfer(i < 4, 1'b0, 10'h3ff, 10'h3fc + 10'(i % 4), 36'({rnd(), rnd()}), 4'hf);
         xfer(1'b1, 1'b1, 10'h0, 10'h3ff, 36'({rnd(), rnd()}), 4'h5);
         xfer(1'b1, 1'b1, 10'h0, 10'h3ff, 36'({rnd(), rnd()}), 4'ha);
         xfer(1'b1, 1'b0, 10'h0, 10'h3ff, 36'({rnd(), rnd()}), 4'h1);
         xfer(1'b0, 1'b1, 10'h0, 10'h3ff, 36'h0, 4'hf);
         xfer(1'b0, 1'b0, 10'h0, 10'h3ff, 36'h0, 4'hf);
         for (int i = 0; i < 20; i++) begin
            v = rnd();
            xfer(v[0], v[1], {8'h0, v[3:2]}, {6'h0, v[7:4]}, 36'({rnd(), rnd()}),
                 v[0] ? v[11:8] : 4'hf);
         end
         repeat (dram_ctl_pkg::C_REF_INTERVAL + 100) @(posedge clk);
         xfer(1'b0, 1'b0, 10'h3ff, 10'h3fc, 36'h0, 4'hf);
         $display("test mode %0d done", m);
      end
      wrap_up();
   end
endmodule
